/* verification/sfc_host.sv */
// Host model driving the register strobe port
`timescale 1ns/10ps
module sfc_host (
  input  wire logic       ref_clk,   // Clock
  input  wire logic [7:0] rd_data,   // Read data
  input  wire logic       rd_valid,  // Read valid
  output logic            wr_strobe, // Write pulse
  output logic            rd_strobe, // Read pulse
  output logic      [7:0] reg_addr,  // Address
  output logic      [7:0] wr_data    // Write data
);
  initial {wr_strobe, rd_strobe, reg_addr, wr_data} = 18'h00000;
  // One write; returns at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {wr_strobe, reg_addr, wr_data} <= {1'b1, a, d};
    @(posedge ref_clk);
    {wr_strobe, reg_addr, wr_data} <= {1'b0, ~a, ~d}; // Released bus shows no stale value
  endtask : wr
  // One read; answer sampled after the next edge
  task automatic rd(input logic [7:0] a, output logic [8:0] g);
    @(posedge ref_clk);
    {rd_strobe, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    {rd_strobe, reg_addr} <= {1'b0, ~a};
    #1;
    g = {rd_valid, rd_data};
  endtask : rd
endmodule : sfc_host

/* verification/special_function_control_regs_tb_top.sv */
// Bench for the special-function control registers
`timescale 1ns/10ps
module special_function_control_regs_tb_top;
  logic       ref_clk = 1'b0, reset = 1'b1, hw_shutdown = 1'b0;
  logic       wr_strobe, rd_strobe, rd_valid, override_active, system_shutdown_n, power_down;
  logic [7:0] reg_addr, wr_data, rd_data;
  int         mismatches = 0, comparisons = 0, cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  sfc_host sfc_host_inst (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_addr(reg_addr), .wr_data(wr_data));
  sfc_control sfc_control_inst (.ref_clk(ref_clk), .reset(reset), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .reg_addr(reg_addr), .wr_data(wr_data), .hw_shutdown(hw_shutdown),
    .rd_data(rd_data), .rd_valid(rd_valid), .override_active(override_active),
    .system_shutdown_n(system_shutdown_n), .power_down(power_down));
  // Verdict and end of run
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Read with valid pulse and data
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [8:0] g;
    sfc_host_inst.rd(a, g);
    chk("read", {1'b1, e}, g);
  endtask : rc
  // Override, shutdown pin, power-down
  task automatic co(input logic [2:0] e);
    #1;
    chk("outputs", {6'h00, e}, {6'h00, override_active, system_shutdown_n, power_down});
  endtask : co
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rc(8'h16, 8'h00);
    rc(8'h17, 8'h00);
    rc(8'h18, 8'h00);
    rc(8'h19, 8'h00);
    co(3'b010);
    sfc_host_inst.wr(8'h16, 8'hff);
    co(3'b100);
    rc(8'h16, 8'h0c);
    sfc_host_inst.wr(8'h17, 8'hff);
    co(3'b101);
    rc(8'h17, 8'h01);
    sfc_host_inst.wr(8'h18, 8'h18);
    co(3'b110);
    @(posedge ref_clk) hw_shutdown <= 1'b1;
    co(3'b100);
    @(posedge ref_clk) hw_shutdown <= 1'b0;
    sfc_host_inst.wr(8'h18, 8'h19);
    rc(8'h18, 8'h19);
    sfc_host_inst.wr(8'h16, 8'h00);
    rc(8'h16, 8'h08);
    sfc_host_inst.wr(8'h18, 8'h00);
    rc(8'h18, 8'h19);
    close_out();
  end
endmodule : special_function_control_regs_tb_top

/* verilog/sfc_cfg.svh */
// Offsets, field positions and reset values of the special-function registers
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH
`define SFC_OFS_ONE       8'h16
`define SFC_OFS_TWO       8'h17
`define SFC_OFS_LOCK      8'h18
`define SFC_RST_ONE       8'h00
`define SFC_RST_TWO       8'h00
`define SFC_RST_LOCK      8'h00
`define SFC_BIT_SW_SYSTEM_SHUTDOWN_N   2
`define SFC_BIT_OVERRIDE  3
`define SFC_BIT_SW_PDOWN  0
`define SFC_BIT_LK_OVR    0
`define SFC_BIT_LK_PDOWN  3
`define SFC_BIT_LK_SYSTEM_SHUTDOWN_N   4
`define SFC_MASK_ONE      8'h0c
`define SFC_MASK_TWO      8'h01
`define SFC_MASK_LOCK     8'h19
`endif

/* verilog/sfc_control.sv */
// Special-function control registers: soft shutdown, override, power-down, lock
`timescale 1ns/10ps
`include "sfc_cfg.svh"
module sfc_control (
  input  wire logic       ref_clk,           // System clock, 200 MHz
  input  wire logic       reset,             // Async reset, high
  input  wire logic       wr_strobe,         // Register write pulse from serial port
  input  wire logic       rd_strobe,         // Register read pulse from serial port
  input  wire logic [7:0] reg_addr,          // Register address
  input  wire logic [7:0] wr_data,           // Write data
  input  wire logic       hw_shutdown,       // Hardware shutdown condition, high
  output logic      [7:0] rd_data,           // Read data, registered
  output logic            rd_valid,          // Read data valid pulse
  output logic            override_active,   // Writes may override permanent settings
  output logic            system_shutdown_n, // Shutdown pin, active low
  output logic            power_down         // Software power-down request
);
  sfc_pkg::reg_byte_t one_q;
  sfc_pkg::reg_byte_t two_q;
  sfc_pkg::reg_byte_t lock_q;
  sfc_pkg::reg_sel_t  sel;
  logic               wr_one;
  logic               wr_two;
  logic               wr_lock;
  logic               ovr_locked;
  sfc_pkg::reg_byte_t one_wr_data;
  sfc_pkg::reg_byte_t rd_mux;
  logic               sw_system_shutdown_n_req;

  // Address decode
  assign sel = (reg_addr == `SFC_OFS_ONE)  ? sfc_pkg::SEL_ONE :
               (reg_addr == `SFC_OFS_TWO)  ? sfc_pkg::SEL_TWO :
               (reg_addr == `SFC_OFS_LOCK) ? sfc_pkg::SEL_LOCK : sfc_pkg::SEL_NONE;
  assign ovr_locked = lock_q[`SFC_BIT_LK_OVR];
  assign wr_one  = wr_strobe && (sel == sfc_pkg::SEL_ONE);
  assign wr_two  = wr_strobe && (sel == sfc_pkg::SEL_TWO);
  assign wr_lock = wr_strobe && (sel == sfc_pkg::SEL_LOCK) && !ovr_locked;
  // Locked: override bit keeps its value, only bits 2:0 take new data
  assign one_wr_data = ovr_locked ? {one_q[7:3], wr_data[2:0]} : wr_data;

  sfc_write_reg #(.RESET_VAL(`SFC_RST_ONE), .WR_MASK(`SFC_MASK_ONE)) u_one (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_one),
    .wr_data (one_wr_data),
    .value_q (one_q)
  );
  sfc_write_reg #(.RESET_VAL(`SFC_RST_TWO), .WR_MASK(`SFC_MASK_TWO)) u_two (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_two),
    .wr_data (wr_data),
    .value_q (two_q)
  );
  sfc_write_reg #(.RESET_VAL(`SFC_RST_LOCK), .WR_MASK(`SFC_MASK_LOCK)) u_lock (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_lock),
    .wr_data (wr_data),
    .value_q (lock_q)
  );

  // Functional outputs
  assign override_active = one_q[`SFC_BIT_OVERRIDE];
  assign sw_system_shutdown_n_req = one_q[`SFC_BIT_SW_SYSTEM_SHUTDOWN_N] && !lock_q[`SFC_BIT_LK_SYSTEM_SHUTDOWN_N];
  assign power_down  = two_q[`SFC_BIT_SW_PDOWN] && !lock_q[`SFC_BIT_LK_PDOWN];
  assign system_shutdown_n = !(sw_system_shutdown_n_req || hw_shutdown);

  // Read mux
  always_comb begin
    unique case (sel)
      sfc_pkg::SEL_ONE:  rd_mux = one_q;
      sfc_pkg::SEL_TWO:  rd_mux = two_q;
      sfc_pkg::SEL_LOCK: rd_mux = lock_q;
      sfc_pkg::SEL_NONE: rd_mux = 8'h00;
    endcase
  end

  // Registered read answer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
      if (rd_strobe) begin
        rd_data <= rd_mux;
      end
    end
  end

  a_system_shutdown_n_soft: assert property (@(posedge ref_clk) disable iff (reset)
    (one_q[2] && !lock_q[4]) |-> !system_shutdown_n)
    else $error("soft shutdown did not pull pin low");
  a_system_shutdown_n_idle: assert property (@(posedge ref_clk) disable iff (reset)
    (!hw_shutdown && !one_q[2]) |-> system_shutdown_n)
    else $error("shutdown pin low without a source");
  a_ovr_follow: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_one && !ovr_locked) |=> (override_active == $past(wr_data[3])))
    else $error("override bit did not take write");
  a_pdown_set: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_two && wr_data[0] && !lock_q[3]) ##1 !lock_q[3] |-> power_down)
    else $error("power-down not entered");
  a_lock_hold: assert property (@(posedge ref_clk) disable iff (reset)
    ovr_locked |=> ($stable(lock_q) && one_q[3] == $past(one_q[3])))
    else $error("locked register changed");
  a_lock_soft: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_one && ovr_locked) |=> one_q[2] == $past(wr_data[2]))
    else $error("soft shutdown bit blocked by lock");
  a_pdown_lock: assert property (@(posedge ref_clk) disable iff (reset)
    lock_q[3] |-> !power_down)
    else $error("power-down while disabled");
  a_system_shutdown_n_lock: assert property (@(posedge ref_clk) disable iff (reset)
    (lock_q[4] && !hw_shutdown) |-> system_shutdown_n)
    else $error("soft shutdown while disabled");
  a_system_shutdown_n_hw: assert property (@(posedge ref_clk) disable iff (reset)
    hw_shutdown |-> !system_shutdown_n)
    else $error("hardware shutdown not on pin");

  // Read request taken on an edge
  sequence s_read_taken;
    rd_strobe;
  endsequence

  // Read answer one cycle later, carrying the selected register
  sequence s_read_answer;
    rd_valid && (rd_data == $past(rd_mux));
  endsequence

  // Read answer follows each read request
  a_rd_answer: assert property (@(posedge ref_clk) disable iff (reset)
    s_read_taken |=> s_read_answer)
    else $error("read answer missing or wrong");

  // Valid is high only in the cycle after a request
  a_rd_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !rd_strobe |=> !rd_valid)
    else $error("read valid without request");

  // Read data holds between reads
  a_rd_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !rd_strobe |=> $stable(rd_data))
    else $error("read data changed without read");

  // Unmapped addresses read as zero
  a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (reset)
    (rd_strobe && (sel == sfc_pkg::SEL_NONE)) |=> (rd_data == 8'h00))
    else $error("unmapped read not zero");

  // Reserved bits of the first register stay zero
  a_rsvd_one: assert property (@(posedge ref_clk) disable iff (reset)
    (one_q & ~`SFC_MASK_ONE) == 8'h00)
    else $error("reserved bit set in first register");

  // Reserved bits of the second register stay zero
  a_rsvd_two: assert property (@(posedge ref_clk) disable iff (reset)
    (two_q & ~`SFC_MASK_TWO) == 8'h00)
    else $error("reserved bit set in second register");

  // Reserved bits of the lock register stay zero
  a_rsvd_lock: assert property (@(posedge ref_clk) disable iff (reset)
    (lock_q & ~`SFC_MASK_LOCK) == 8'h00)
    else $error("reserved bit set in lock register");

  // Second register always writable, lock or not
  a_wr_two: assert property (@(posedge ref_clk) disable iff (reset)
    wr_two |=> (two_q == $past(wr_data & `SFC_MASK_TWO)))
    else $error("second register write lost");

  // Lock register takes writes while open
  a_wr_lock_open: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_strobe && (sel == sfc_pkg::SEL_LOCK) && !ovr_locked)
      |=> (lock_q == $past(wr_data & `SFC_MASK_LOCK)))
    else $error("lock register write lost");

  // Override bit kept while locked
  a_lock_ovr_keep: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_one && ovr_locked) |=> (one_q[3] == $past(one_q[3])))
    else $error("override bit changed while locked");

  // Power-down bit still writable while locked
  a_lock_two_open: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_two && ovr_locked) |=> (two_q[0] == $past(wr_data[0])))
    else $error("power-down bit blocked by lock");

  // Stored power-down request reaches the output when allowed
  a_pdown_free: assert property (@(posedge ref_clk) disable iff (reset)
    (two_q[0] && !lock_q[3]) |-> power_down)
    else $error("power-down request not on output");

  // No power-down without the stored request
  a_pdown_off: assert property (@(posedge ref_clk) disable iff (reset)
    !two_q[0] |-> !power_down)
    else $error("power-down without request");

  // Override output clear while its bit is clear
  a_ovr_off: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_one && !ovr_locked && !wr_data[3]) |=> !override_active)
    else $error("override stayed active after clear");

  // Soft shutdown write reaches the pin one cycle later
  a_system_shutdown_n_write: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_one && wr_data[2] && !lock_q[4]) ##1 !lock_q[4] |-> !system_shutdown_n)
    else $error("soft shutdown write not on pin");
endmodule : sfc_control

/* verilog/sfc_pkg.sv */
// Types shared by the special-function control block
package sfc_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_ONE,
    SEL_TWO,
    SEL_LOCK
  } reg_sel_t;
endpackage : sfc_pkg

/* verilog/sfc_write_reg.sv */
// One byte-wide writable control register with a write mask
`timescale 1ns/10ps
module sfc_write_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hff
) (
  input  wire logic       ref_clk,  // System clock
  input  wire logic       reset,    // Async reset, high
  input  wire logic       wr_en,    // Write this register
  input  wire logic [7:0] wr_data,  // Write data
  output logic      [7:0] value_q   // Stored value
);
  logic [7:0] value_d;

  // Only writable bits take new data; reserved bits stay zero
  assign value_d = wr_en ? (wr_data & WR_MASK) : value_q;

  // Storage
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end
endmodule : sfc_write_reg
